// ===== hw/lpei_pa_cmp.sv
// Purpose: One transmit channel power threshold check
// Assumes: Power words come from the transmit measurement logic on mclk
// Notes:   Registered so the compare does not sit in the status path
`timescale 1ns/1ps
module lpei_pa_cmp
    import lpei_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         en,
    input  wire lpei_pa_pwr_t pwr,
    input  wire logic [PWR_W-1:0] peak_thr,
    input  wire logic [PWR_W-1:0] avg_thr,
    output logic              err
);
    logic err_nxt;

    always_comb begin
        err_nxt = en & ((pwr.peak > peak_thr) | (pwr.avg > avg_thr));
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            err <= 1'b0;
        end else begin
            err <= err_nxt;
        end
    end
endmodule

// ===== hw/lpei_pkg.sv
// Purpose: Constants and carrier types for the link and power amplifier error interrupt block
// Assumes: 200 MHz mclk, AHB-Lite register access, 32-bit data
// Notes:   Status bit positions follow the device interrupt map
package lpei_pkg;
    localparam int STAT_W  = 50;
    localparam int HI_W    = STAT_W - 32;
    localparam int PWR_W   = 16;
    localparam int ATT_W   = 8;
    localparam int N_TX    = 4;
    localparam int N_CPU   = 4;
    localparam int N_DFRM  = 2;
    localparam int N_FRM   = 3;
    localparam int N_DEV   = 6;
    localparam int N_FEV   = 3;
    localparam int N_QSRC  = 3;
    localparam int SEL_W   = N_DFRM * N_DEV;
    localparam int SUM_W   = N_DFRM * N_QSRC;

    // Status bit positions
    localparam int BIT_CPU0 = 12;
    localparam int BIT_PA0  = 16;
    localparam int DFRM_BIT [0:1][0:5] = '{'{29, 30, 31, 32, 33, 34}, '{35, 36, 37, 38, 48, 49}};
    localparam int FRM_BIT  [0:2][0:2] = '{'{20, 21, 22}, '{23, 24, 25}, '{26, 27, 28}};
    localparam int EV_FIFO = 0;
    localparam int EV_ELAS = 1;
    localparam int EV_SREF = 2;
    localparam int EV_SUM  = 3;
    localparam int EV_LOSS = 4;
    localparam int EV_CRC  = 5;
    localparam int FE_FIFO = 0;
    localparam int FE_SREF = 1;
    localparam int FE_TNSD = 2;
    // Positions fed straight from the misc input: stream, ECC, PLL and spare sources
    localparam logic [STAT_W-1:0] MISC_MASK = 50'h0ff8000000fff;

    // Register byte offsets
    localparam logic [7:0] A_STAT_LO  = 8'h00;
    localparam logic [7:0] A_STAT_HI  = 8'h04;
    localparam logic [7:0] A_MASK1_LO = 8'h08;
    localparam logic [7:0] A_MASK1_HI = 8'h0c;
    localparam logic [7:0] A_MASK2_LO = 8'h10;
    localparam logic [7:0] A_MASK2_HI = 8'h14;
    localparam logic [7:0] A_CTRL     = 8'h18;
    localparam logic [7:0] A_PA_THR   = 8'h1c;
    localparam logic [7:0] A_RAMP_SEL = 8'h20;
    localparam logic [7:0] A_SUM_SRC  = 8'h24;
    localparam logic [7:0] A_RAMP_ST  = 8'h28;

    // Control fields
    localparam int CTRL_PA_EN   = 0;
    localparam int CTRL_RAMP_EN = 1;
    localparam int CTRL_STICKY  = 2;
    localparam int CTRL_RCLR    = 3;
    localparam int CTRL_RELINK  = 4;
    localparam int CTRL_W       = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [STAT_W-1:0] MASK_RST = '1;
    localparam logic [31:0] THR_RST = 32'hffffffff;
    localparam int THR_AVG_LSB = 16;

    // Attenuation ramp step timing
    localparam int MCLK_PS      = 5000;
    localparam int RAMP_STEP_NS = 1000;
    localparam int RAMP_CYC     = (RAMP_STEP_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
    localparam logic [ATT_W-1:0] ATT_MAX = 8'hff;

    typedef struct packed {
        logic fifo;
        logic elastic;
        logic sysref;
        logic bd;
        logic nit;
        logic uek;
        logic loss_sync;
        logic crc;
    } lpei_dfrm_ev_t;

    typedef struct packed {
        logic fifo;
        logic sysref;
        logic tnsd;
    } lpei_frm_ev_t;

    typedef struct packed {
        logic [PWR_W-1:0] peak;
        logic [PWR_W-1:0] avg;
    } lpei_pa_pwr_t;
endpackage

// ===== hw/lpei_sticky.sv
// Purpose: Bank of sticky flags, set by hardware, cleared by write-one
// Assumes: Set and clear arrive on mclk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module lpei_sticky #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_nxt;

    always_comb begin
        q_nxt = (q & ~clr) | set;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= q_nxt;
        end
    end
endmodule

// ===== hw/lpei_top.sv
// Purpose: Interrupt source collector with two masked pins and an AHB-Lite register file
// Assumes: All event inputs come from logic on mclk; zero wait-state slave
// Notes:   Only address bits 7:0 are decoded, so the map aliases inside the slot
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module lpei_top
    import lpei_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire lpei_dfrm_ev_t     dfrm_ev [N_DFRM],
    input  wire lpei_frm_ev_t      frm_ev [N_FRM],
    input  wire logic [N_CPU-1:0]  cpu_ev,
    input  wire lpei_pa_pwr_t      pa_pwr [N_TX],
    input  wire logic [STAT_W-1:0] misc_ev,
    output logic                   first_interrupt_pin,
    output logic                   second_interrupt_pin,
    output logic      [N_FRM-1:0]  framer_relink,
    output logic                   ramp_active,
    output logic      [ATT_W-1:0]  ramp_atten
);
    logic [STAT_W-1:0] src;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_clr;
    logic [STAT_W-1:0] mask1_r;
    logic [STAT_W-1:0] mask1_nxt;
    logic [STAT_W-1:0] mask2_r;
    logic [STAT_W-1:0] mask2_nxt;
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [31:0]       thr_r;
    logic [31:0]       thr_nxt;
    logic [SEL_W-1:0]  sel_r;
    logic [SEL_W-1:0]  sel_nxt;
    logic [SUM_W-1:0]  sum_set;
    logic [SUM_W-1:0]  sum_clr;
    logic [SUM_W-1:0]  sum_q;
    logic [SEL_W-1:0]  dfrm_vec;
    logic [N_TX-1:0]   pa_err;
    logic              ph_valid_r;
    logic              ph_write_r;
    logic [7:0]        ph_addr_r;
    logic              ph_valid_nxt;
    logic              ph_write_nxt;
    logic [7:0]        ph_addr_nxt;
    logic [31:0]       rdata_nxt;
    logic              wr_en;
    logic              rclr;
    logic              pin1_nxt;
    logic              pin2_nxt;
    logic [N_FRM-1:0]  relink_nxt;
    logic              trig;
    logic              ramp_nxt;
    logic [ATT_W-1:0]  atten_nxt;
    logic [15:0]       tick_r;
    logic [15:0]       tick_nxt;
    logic              tick;

    // Power comparators, one per transmit channel
    for (genvar t = 0; t < N_TX; t++) begin : g_pa
        lpei_pa_cmp u_cmp (
            .mclk     (mclk),
            .resetn   (resetn),
            .en       (ctrl_r[CTRL_PA_EN]),
            .pwr      (pa_pwr[t]),
            .peak_thr (thr_r[PWR_W-1:0]),
            .avg_thr  (thr_r[THR_AVG_LSB +: PWR_W]),
            .err      (pa_err[t])
        );
    end

    // Live source vector
    always_comb begin
        src = misc_ev & MISC_MASK;
        dfrm_vec = '0;
        sum_set = '0;
        for (int c = 0; c < N_CPU; c++) begin
            src[BIT_CPU0 + c] = cpu_ev[c];
        end
        for (int t = 0; t < N_TX; t++) begin
            src[BIT_PA0 + t] = pa_err[t];
        end
        for (int f = 0; f < N_FRM; f++) begin
            src[FRM_BIT[f][FE_FIFO]] = frm_ev[f].fifo;
            src[FRM_BIT[f][FE_SREF]] = frm_ev[f].sysref;
            src[FRM_BIT[f][FE_TNSD]] = frm_ev[f].tnsd;
        end
        for (int d = 0; d < N_DFRM; d++) begin
            dfrm_vec[d*N_DEV + EV_FIFO] = dfrm_ev[d].fifo;
            dfrm_vec[d*N_DEV + EV_ELAS] = dfrm_ev[d].elastic;
            dfrm_vec[d*N_DEV + EV_SREF] = dfrm_ev[d].sysref;
            dfrm_vec[d*N_DEV + EV_SUM]  = dfrm_ev[d].bd | dfrm_ev[d].nit | dfrm_ev[d].uek;
            dfrm_vec[d*N_DEV + EV_LOSS] = dfrm_ev[d].loss_sync;
            // Not gated by link mode: the flag can be spurious in B mode
            dfrm_vec[d*N_DEV + EV_CRC]  = dfrm_ev[d].crc;
            sum_set[d*N_QSRC +: N_QSRC] = {dfrm_ev[d].bd, dfrm_ev[d].nit, dfrm_ev[d].uek};
            for (int e = 0; e < N_DEV; e++) begin
                src[DFRM_BIT[d][e]] = dfrm_vec[d*N_DEV + e];
            end
        end
    end

    lpei_sticky #(.W(STAT_W)) u_stat (
        .mclk   (mclk),
        .resetn (resetn),
        .set    (src),
        .clr    (stat_clr),
        .q      (stat_q)
    );

    lpei_sticky #(.W(SUM_W)) u_sum (
        .mclk   (mclk),
        .resetn (resetn),
        .set    (sum_set),
        .clr    (sum_clr),
        .q      (sum_q)
    );

    // AHB-Lite: reads answered from a flop in the data phase, writes taken in the data phase
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (a)
            A_STAT_LO:  v = stat_q[31:0];
            A_STAT_HI:  v = 32'(stat_q[STAT_W-1:32]);
            A_MASK1_LO: v = mask1_r[31:0];
            A_MASK1_HI: v = 32'(mask1_r[STAT_W-1:32]);
            A_MASK2_LO: v = mask2_r[31:0];
            A_MASK2_HI: v = 32'(mask2_r[STAT_W-1:32]);
            A_CTRL:     v = 32'(ctrl_r);
            A_PA_THR:   v = thr_r;
            A_RAMP_SEL: v = 32'(sel_r);
            A_SUM_SRC:  v = 32'(sum_q);
            A_RAMP_ST:  v = 32'({ramp_atten, ramp_active});
            default:    v = 32'h00000000;
        endcase
        return v;
    endfunction

    always_comb begin
        ph_valid_nxt = hsel & hready & htrans[1];
        ph_write_nxt = hwrite;
        ph_addr_nxt  = haddr[7:0];
        rdata_nxt    = (ph_valid_nxt & ~hwrite) ? rd_mux(haddr[7:0]) : 32'h00000000;
        wr_en        = ph_valid_r & ph_write_r;
        stat_clr     = '0;
        sum_clr      = '0;
        mask1_nxt    = mask1_r;
        mask2_nxt    = mask2_r;
        ctrl_nxt     = ctrl_r;
        thr_nxt      = thr_r;
        sel_nxt      = sel_r;
        rclr         = 1'b0;
        if (wr_en) begin
            unique case (ph_addr_r)
                A_STAT_LO:  stat_clr[31:0] = hwdata;
                A_STAT_HI:  stat_clr[STAT_W-1:32] = hwdata[HI_W-1:0];
                A_MASK1_LO: mask1_nxt[31:0] = hwdata;
                A_MASK1_HI: mask1_nxt[STAT_W-1:32] = hwdata[HI_W-1:0];
                A_MASK2_LO: mask2_nxt[31:0] = hwdata;
                A_MASK2_HI: mask2_nxt[STAT_W-1:32] = hwdata[HI_W-1:0];
                A_CTRL: begin
                    ctrl_nxt = hwdata[CTRL_W-1:0];
                    ctrl_nxt[CTRL_RCLR] = 1'b0;
                    rclr = hwdata[CTRL_RCLR];
                end
                A_PA_THR:   thr_nxt = hwdata;
                A_RAMP_SEL: sel_nxt = hwdata[SEL_W-1:0];
                A_SUM_SRC:  sum_clr = hwdata[SUM_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r  <= 8'h00;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            mask1_r    <= MASK_RST;
            mask2_r    <= MASK_RST;
            ctrl_r     <= CTRL_RST;
            thr_r      <= THR_RST;
            sel_r      <= '0;
        end else begin
            ph_valid_r <= ph_valid_nxt;
            ph_write_r <= ph_write_nxt;
            ph_addr_r  <= ph_addr_nxt;
            hrdata     <= rdata_nxt;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            mask1_r    <= mask1_nxt;
            mask2_r    <= mask2_nxt;
            ctrl_r     <= ctrl_nxt;
            thr_r      <= thr_nxt;
            sel_r      <= sel_nxt;
        end
    end

    // Pins follow the live sources, not the sticky word, so they drop once the cause goes
    always_comb begin
        pin1_nxt = |(src & ~mask1_r);
        pin2_nxt = |(src & ~mask2_r);
        relink_nxt = '0;
        for (int f = 0; f < N_FRM; f++) begin
            relink_nxt[f] = frm_ev[f].sysref & ctrl_r[CTRL_RELINK];
        end
    end

    // Attenuation ramp; a trigger in the clearing cycle keeps the ramp on
    always_comb begin
        trig = (ctrl_r[CTRL_RAMP_EN] & (|pa_err)) | (|(dfrm_vec & sel_r));
        ramp_nxt = trig | (ramp_active & ctrl_r[CTRL_STICKY] & ~rclr);
        tick = (tick_r == 16'(RAMP_CYC - 1));
        tick_nxt = (tick | ~ramp_active) ? 16'h0000 : tick_r + 16'h0001;
        if (!ramp_nxt) begin
            atten_nxt = '0;
        end else if (tick && ramp_atten != ATT_MAX) begin
            atten_nxt = ramp_atten + 8'h01;
        end else begin
            atten_nxt = ramp_atten;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            first_interrupt_pin  <= 1'b0;
            second_interrupt_pin <= 1'b0;
            framer_relink        <= '0;
            ramp_active          <= 1'b0;
            ramp_atten           <= '0;
            tick_r               <= 16'h0000;
        end else begin
            first_interrupt_pin  <= pin1_nxt;
            second_interrupt_pin <= pin2_nxt;
            framer_relink        <= relink_nxt;
            ramp_active          <= ramp_nxt;
            ramp_atten           <= atten_nxt;
            tick_r               <= tick_nxt;
        end
    end

    // Checks
    a_stat_latch: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 ((($past(stat_q) & ~$past(stat_clr)) & ~stat_q) == '0))
        else $error("status bit dropped without a clear");
    a_set_wins: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 (($past(src) & ~stat_q) == '0))
        else $error("active source not latched");
    a_pin1_mask: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 (first_interrupt_pin == $past(|(src & ~mask1_r))))
        else $error("first pin does not match masked sources");
    a_pin2_mask: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 (second_interrupt_pin == $past(|(src & ~mask2_r))))
        else $error("second pin does not match masked sources");
    a_pa_gated: assert property (@(posedge mclk) disable iff (!resetn)
        !ctrl_r[CTRL_PA_EN] [*2] |-> (src[BIT_PA0 +: N_TX] == '0))
        else $error("power error while protection disabled");
    a_pa_thresh: assert property (@(posedge mclk) disable iff (!resetn)
        (ctrl_r[CTRL_PA_EN] && pa_pwr[0].peak > thr_r[PWR_W-1:0]) |-> ##2 stat_q[BIT_PA0])
        else $error("peak over threshold not flagged");
    a_summary_src: assert property (@(posedge mclk) disable iff (!resetn)
        (dfrm_ev[1].nit) |=> (stat_q[DFRM_BIT[1][EV_SUM]] && sum_q[N_QSRC + 1]))
        else $error("summary or source missing");
    a_crc_flag: assert property (@(posedge mclk) disable iff (!resetn)
        dfrm_ev[1].crc |=> stat_q[DFRM_BIT[1][EV_CRC]])
        else $error("deframer crc not flagged");
    a_ramp_trig: assert property (@(posedge mclk) disable iff (!resetn)
        (ctrl_r[CTRL_RAMP_EN] && (|pa_err)) |=> ramp_active)
        else $error("ramp not started");
    a_ramp_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        (ramp_active && ctrl_r[CTRL_STICKY] && !rclr) |=> ramp_active)
        else $error("sticky ramp cleared itself");
    a_relink: assert property (@(posedge mclk) disable iff (!resetn)
        (frm_ev[1].sysref && ctrl_r[CTRL_RELINK]) |=> framer_relink[1])
        else $error("framer relink missing");
    c_pin1: cover property (@(posedge mclk) disable iff (!resetn) $rose(first_interrupt_pin));
    c_ramp: cover property (@(posedge mclk) disable iff (!resetn) ramp_active && ramp_atten == 8'h02);
    c_clr: cover property (@(posedge mclk) disable iff (!resetn) stat_q[BIT_PA0] ##1 !stat_q[BIT_PA0]);
endmodule

// ===== verification/lpei_bbp_model.sv
// Purpose: Baseband processor model watching both interrupt pins
// Assumes: Pins are synchronous to mclk
// Notes:   Counts rising edges, since the pins are levels and not sticky
`timescale 1ns/1ps
module lpei_bbp_model (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic pin1,
    input  wire logic pin2,
    output int        rise1,
    output int        rise2
);
    logic p1_r;
    logic p2_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            p1_r  <= 1'b0;
            p2_r  <= 1'b0;
            rise1 <= 0;
            rise2 <= 0;
        end else begin
            p1_r <= pin1;
            p2_r <= pin2;
            if (pin1 && !p1_r) rise1 <= rise1 + 1;
            if (pin2 && !p2_r) rise2 <= rise2 + 1;
        end
    end
endmodule

// ===== verification/test_link_and_pa_error_interrupt_sources.sv
// Purpose: Self-checking bench for the interrupt source collector
// Assumes: Zero wait-state AHB-Lite slave, 200 MHz mclk
// Notes:   Host masks keep charge pump and 204C-only bits set throughout
`timescale 1ns/1ps
module test_link_and_pa_error_interrupt_sources
    import lpei_pkg::*;
;
    localparam int EVM [8] = '{0, 1, 2, 3, 3, 3, 4, 5};
    logic              mclk, resetn, hsel, hwrite, rd_dph;
    logic [31:0]       haddr, hwdata, m;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       hrdata;
    logic              hreadyout, hresp, pin1, pin2, ramp_active;
    logic [N_FRM-1:0]  relink;
    logic [ATT_W-1:0]  atten;
    lpei_dfrm_ev_t     dfrm [N_DFRM];
    lpei_frm_ev_t      frm [N_FRM];
    logic [N_CPU-1:0]  cpu;
    lpei_pa_pwr_t      pwr [N_TX];
    logic [STAT_W-1:0] misc, e;
    logic [31:0]       exp_q [$];
    int                n_mismatch, n_checks, cyc, r1, r2;

    lpei_top u_lpei_top (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .dfrm_ev(dfrm), .frm_ev(frm), .cpu_ev(cpu), .pa_pwr(pwr),
        .misc_ev(misc), .first_interrupt_pin(pin1), .second_interrupt_pin(pin2),
        .framer_relink(relink), .ramp_active(ramp_active), .ramp_atten(atten));
    lpei_bbp_model u_lpei_bbp_model (.mclk(mclk), .resetn(resetn), .pin1(pin1), .pin2(pin2),
        .rise1(r1), .rise2(r2));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(string what, logic [63:0] got, logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic w(int n);
        repeat (n) @(posedge mclk);
    endtask

    // Address phase held until hready, then data phase held until hready
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_dph <= !wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd_dph <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask

    // Checks the whole status word, then clears it by write-one
    task automatic rd_stat(logic [STAT_W-1:0] x);
        rd(A_STAT_LO, x[31:0]);
        rd(A_STAT_HI, {14'h0, x[49:32]});
        bus(1'b1, A_STAT_LO, '1);
        bus(1'b1, A_STAT_HI, '1);
    endtask

    always @(posedge mclk) begin
        if (rd_dph && hreadyout) chk("hrdata", hrdata, exp_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        {resetn, hsel, hwrite, rd_dph, haddr, hwdata, htrans, cpu, misc} = '0;
        hsize = 3'b010;
        dfrm = '{default: '0};
        frm = '{default: '0};
        pwr = '{default: '0};
        void'($urandom(32'h1e71e29e));
        w(12);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(A_MASK1_LO, 32'hffffffff);
        rd(A_MASK2_HI, 32'h0003ffff);
        rd(A_PA_THR, 32'hffffffff);
        rd(8'h2c, 32'h0);
        rd_stat('0);
        chk("pins", {pin1, pin2, hresp}, 3'b000);
        $display("reset test done");
        for (int d = 0; d < N_DFRM; d++) for (int k = 0; k < 8; k++) begin
            dfrm[d] <= lpei_dfrm_ev_t'(8'h80 >> k);
            w(1);
            dfrm[d] <= '0;
            e = '0;
            e[DFRM_BIT[d][EVM[k]]] = 1'b1;
            w(1);
            rd_stat(e);
            if (k inside {[3:5]}) rd(A_SUM_SRC, 32'h1 << (d * 3 + 5 - k));
            bus(1'b1, A_SUM_SRC, '1);
        end
        for (int f = 0; f < N_FRM; f++) for (int k = 0; k < 3; k++) begin
            frm[f] <= lpei_frm_ev_t'(3'b100 >> k);
            w(1);
            frm[f] <= '0;
            w(1);
            rd_stat(50'h1 << FRM_BIT[f][k]);
        end
        for (int i = 0; i < N_CPU; i++) begin
            cpu <= 4'h1 << i;
            w(1);
            cpu <= '0;
            w(1);
            rd_stat(50'h1 << (BIT_CPU0 + i));
        end
        m = $urandom;
        misc <= {m[17:0], m};
        w(1);
        misc <= '0;
        w(1);
        rd_stat({m[17:0], m} & MISC_MASK);
        $display("event map test done");
        // Upper mask words stay all ones, keeping charge pump and 204C-only bits off the pins
        bus(1'b1, A_MASK1_LO, ~(32'h1 << BIT_CPU0));
        cpu <= 4'h1;
        w(2);
        chk("pin pair", {pin1, pin2}, 2'b10);
        cpu <= 4'h0;
        w(2);
        chk("pin pair", {pin1, pin2}, 2'b00);
        bus(1'b1, A_MASK1_LO, '1);
        bus(1'b1, A_MASK2_LO, ~(32'h1 << BIT_CPU0));
        cpu <= 4'h1;
        w(2);
        chk("pin pair", {pin1, pin2}, 2'b01);
        cpu <= 4'h0;
        rd_stat(50'h1 << BIT_CPU0);
        chk("rise count", {r1[7:0], r2[7:0]}, 16'h0101);
        bus(1'b1, A_MASK2_LO, '1);
        $display("pin mask test done");
        bus(1'b1, A_PA_THR, 32'h08001000);
        pwr[0] <= {16'h2000, 16'h2000};
        w(3);
        pwr[0] <= '0;
        rd_stat('0);
        bus(1'b1, A_CTRL, 32'h1);
        for (int ch = 0; ch < N_TX; ch++) begin
            pwr[ch] <= ch[0] ? {16'h0, 16'h0801} : {16'h1001, 16'h0};
            w(3);
            pwr[ch] <= '0;
            w(2);
            rd_stat(50'h1 << (BIT_PA0 + ch));
        end
        $display("power test done");
        bus(1'b1, A_RAMP_SEL, 32'h1 << EV_CRC);
        bus(1'b1, A_CTRL, 32'h7);
        dfrm[0] <= lpei_dfrm_ev_t'(8'h01);
        w(1);
        dfrm[0] <= '0;
        w(4);
        rd(A_RAMP_ST, 32'h1);
        w(210);
        chk("atten", atten, 8'h01);
        bus(1'b1, A_CTRL, 32'hf);
        w(2);
        chk("ramp", {ramp_active, atten}, 9'h000);
        rd_stat(50'h1 << DFRM_BIT[0][EV_CRC]);
        bus(1'b1, A_CTRL, 32'h3);
        pwr[2] <= {16'h1001, 16'h0};
        w(4);
        chk("ramp", ramp_active, 1'b1);
        pwr[2] <= '0;
        w(5);
        chk("ramp", ramp_active, 1'b0);
        rd_stat(50'h1 << (BIT_PA0 + 2));
        $display("ramp test done");
        bus(1'b1, A_CTRL, 32'h10);
        frm[1] <= lpei_frm_ev_t'(3'b010);
        w(2);
        chk("relink", relink, 3'b010);
        frm[1] <= '0;
        w(2);
        chk("relink", relink, 3'b000);
        rd_stat(50'h1 << FRM_BIT[1][FE_SREF]);
        $display("relink test done");
        tally_and_finish();
    end
endmodule
